// file: inc/synth_i2c_pkg.sv
// Shared constants for the serial register port of the clock synthesizer
package synth_i2c_pkg;
    // ------------------------------------------------------------
    // Bus addressing
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_UPPER = 6'h13;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    localparam logic ACK_LEVEL = 1'b0;
    localparam logic NACK_LEVEL = 1'b1;
    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    localparam int REG_COUNT = 32;
    localparam int IDX_W = 8;
    localparam logic [7:0] LOOP_FILTER_IDX = 8'h04;
    localparam int LOOP_FILTER_BIT = 7;
    localparam logic [7:0] WORD_RESET = 8'h00;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_NS = 40;
    localparam int LINK_HALF_NS = 160;
    localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLOCK_NS - 1) / CLOCK_NS;
endpackage

// file: inc/synth_i2c_if.sv
// Two-wire bus joining the master and the register port
`timescale 1ns/1ns
`default_nettype none
interface synth_i2c_if;
    logic sclOut;   // Master drives clock low
    logic sclOe;
    logic sdaMstOut;
    logic sdaMstOe;
    logic sdaDevOut;
    logic sdaDevOe;
    logic scl;      // Resolved wire levels, made by the bench
    logic sda;
    modport master (output sclOut, sclOe, sdaMstOut, sdaMstOe, input scl, sda);
    modport device (output sdaDevOut, sdaDevOe, input scl, sda);
endinterface
`default_nettype wire

// file: hdl/synth_i2c_device.sv
// Register port end of the two-wire link, with loop filter select output
//
// How it works
// - Index 4 bit 7 picks internal filter
// - Address is 010011 then select pin
// - Single write: address, index, data, all acked
// - Single read via repeated start, master nacks
// - Multi write stores successive registers
// - Multi read returns successive registers
// - Bytes move most significant bit first
// - Ack is low, nack is high
// - Lower index nibble increments per data byte
// - Upper index nibble never gets carry
// - Master splits access into two transactions
`timescale 1ns/1ns
`default_nettype none
module synth_i2c_device
    import synth_i2c_pkg::*;
(
    input wire logic clock,          // System clock
    input wire logic rst_b,          // Synchronous reset, active low
    synth_i2c_if.device bus,         // Two-wire bus
    input wire logic busAddressSelectPin, // Address select strap
    output logic internalFilterSel,  // 1 = internal loop filter
    output logic [7:0] regIndex      // Current register index
);
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_ADDR = 5'b00010,
        S_INDEX = 5'b00100,
        S_WDATA = 5'b01000,
        S_RDATA = 5'b10000
    } dstate_e;

    // ------------------------------------------------------------
    // Input synchronisers and edge detection
    // ------------------------------------------------------------
    logic [2:0] sclSyncReg, sclSyncNext, sdaSyncReg, sdaSyncNext;
    logic selSync1Reg, selSync2Reg;
    logic sclRise, sclFall, startSeen, stopSeen;

    // Third stage only feeds edge detect, so first stage stays clean
    always_comb begin
        sclSyncNext = {sclSyncReg[1:0], bus.scl};
        sdaSyncNext = {sdaSyncReg[1:0], bus.sda};
    end
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sclSyncReg <= 3'h7;
            sdaSyncReg <= 3'h7;
            selSync1Reg <= 1'b0;
            selSync2Reg <= 1'b0;
        end else begin
            sclSyncReg <= sclSyncNext;
            sdaSyncReg <= sdaSyncNext;
            selSync1Reg <= busAddressSelectPin;
            selSync2Reg <= selSync1Reg;
        end
    end
    assign sclRise = sclSyncReg[1] && !sclSyncReg[2];
    assign sclFall = !sclSyncReg[1] && sclSyncReg[2];
    assign startSeen = sclSyncReg[1] && sclSyncReg[2] && !sdaSyncReg[1] && sdaSyncReg[2];
    assign stopSeen = sclSyncReg[1] && sclSyncReg[2] && sdaSyncReg[1] && !sdaSyncReg[2];

    // ------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------
    dstate_e stateReg, stateNext;
    logic [3:0] bitCntReg, bitCntNext;
    logic [7:0] shiftReg, shiftNext, indexReg, indexNext;
    logic ackReg, ackNext, driveReg, driveNext, readReg, readNext;
    // START is followed by a clock fall that is not a bit; this count wraps to 0 on it
    localparam logic [3:0] BIT_START = 4'hf;
    logic [7:0] regs [REG_COUNT];
    logic wrEn;
    logic [7:0] wrData, rdByte;

    // Only lower nibble advances; the upper nibble is held
    function automatic logic [7:0] bump(input logic [7:0] idx);
        bump = {idx[7:4], idx[3:0] + 4'h1};
    endfunction

    assign rdByte = regs[indexReg[4:0]];

    always_comb begin
        stateNext = stateReg;
        bitCntNext = bitCntReg;
        shiftNext = shiftReg;
        indexNext = indexReg;
        ackNext = ackReg;
        driveNext = driveReg;
        readNext = readReg;
        wrEn = 1'b0;
        wrData = shiftReg;
        if (startSeen) begin
            stateNext = S_ADDR;
            bitCntNext = BIT_START;
            driveNext = 1'b0;
        end else if (stopSeen) begin
            stateNext = S_IDLE;
            driveNext = 1'b0;
        end else if (sclRise && stateReg != S_IDLE) begin
            if (bitCntReg == BIT_ACK) begin
                // Master nack ends a read burst
                if (readReg && sdaSyncReg[1] == NACK_LEVEL) begin
                    stateNext = S_IDLE;
                end
            end else if (stateReg != S_RDATA) begin
                // Read bytes shift out on falls only; a rise must not disturb them
                shiftNext = {shiftReg[6:0], sdaSyncReg[1]};
            end
        end else if (sclFall && stateReg != S_IDLE) begin
            driveNext = 1'b0;
            if (bitCntReg == BIT_LAST) begin
                bitCntNext = BIT_ACK;
                ackNext = 1'b0;
                case (stateReg)
                    S_ADDR: begin
                        // Foreign address leaves line released until next start
                        if (shiftReg[7:1] == {ADDR_UPPER, selSync2Reg}) begin
                            ackNext = 1'b1;
                            readNext = shiftReg[0] == DIR_READ;
                        end else begin
                            stateNext = S_IDLE;
                        end
                    end
                    S_INDEX: begin
                        ackNext = 1'b1;
                        indexNext = shiftReg;
                    end
                    S_WDATA: begin
                        ackNext = 1'b1;
                        wrEn = 1'b1;
                        indexNext = bump(indexReg);
                    end
                    default: begin
                    end
                endcase
                driveNext = ackNext;
            end else if (bitCntReg == BIT_ACK) begin
                bitCntNext = 4'h0;
                case (stateReg)
                    S_ADDR: stateNext = readReg ? S_RDATA : S_INDEX;
                    S_INDEX: stateNext = S_WDATA;
                    default: stateNext = stateReg;
                endcase
                if (stateNext == S_RDATA) begin
                    shiftNext = {rdByte[6:0], 1'b0};
                    driveNext = !rdByte[7];
                    indexNext = bump(indexReg);
                end
            end else begin
                bitCntNext = bitCntReg + 4'h1;
                if (stateReg == S_RDATA) begin
                    driveNext = !shiftReg[7];
                    shiftNext = {shiftReg[6:0], 1'b0};
                end
            end
        end
    end

    // Open-drain: only ever pull low
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            stateReg <= S_IDLE;
            bitCntReg <= 4'h0;
            shiftReg <= WORD_RESET;
            indexReg <= WORD_RESET;
            ackReg <= 1'b0;
            driveReg <= 1'b0;
            readReg <= 1'b0;
        end else begin
            stateReg <= stateNext;
            bitCntReg <= bitCntNext;
            shiftReg <= shiftNext;
            indexReg <= indexNext;
            ackReg <= ackNext;
            driveReg <= driveNext;
            readReg <= readNext;
        end
    end

    // Register array; no reset on storage to keep it a plain memory
    always_ff @(posedge clock) begin
        if (wrEn) begin
            regs[indexReg[4:0]] <= wrData;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic filterReg, filterNext;
    always_comb begin
        filterNext = filterReg;
        if (wrEn && indexReg == LOOP_FILTER_IDX) begin
            filterNext = wrData[LOOP_FILTER_BIT];
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            filterReg <= 1'b0;
        end else begin
            filterReg <= filterNext;
        end
    end
    assign internalFilterSel = filterReg;
    assign regIndex = indexReg;
    assign bus.sdaDevOut = 1'b0;
    assign bus.sdaDevOe = driveReg;
endmodule
`default_nettype wire

// file: hdl/synth_i2c_master.sv
// Host end: drives two-wire transactions to the register port
`timescale 1ns/1ns
`default_nettype none
module synth_i2c_master
    import synth_i2c_pkg::*;
(
    input wire logic clock,        // System clock
    input wire logic rst_b,        // Synchronous reset, active low
    synth_i2c_if.master bus,       // Two-wire bus
    input wire logic cmdValid,     // Start a transaction
    input wire logic cmdRead,      // 1 = read burst
    input wire logic addrSel,      // Device address low bit
    input wire logic [7:0] cmdIndex, // Register index
    input wire logic [3:0] cmdLen, // Data bytes, 1..15
    input wire logic [7:0] wrByte, // Write data for current byte
    output logic cmdReady,         // Idle, can take command
    output logic byteStrobe,       // Data byte done pulse
    output logic [7:0] rdByte,     // Last byte read
    output logic nackSeen          // Device nacked last transaction
);
    typedef enum logic [6:0] {
        M_IDLE = 7'b0000001, M_START = 7'b0000010, M_BYTE = 7'b0000100,
        M_ACK = 7'b0001000, M_RSTART = 7'b0010000, M_STOP = 7'b0100000,
        M_DONE = 7'b1000000
    } mstate_e;

    mstate_e stateReg, stateNext;
    logic [1:0] phaseReg, phaseNext;
    logic [7:0] timeReg, timeNext, shiftReg, shiftNext, rdReg, rdNext;
    logic [3:0] bitReg, bitNext, leftReg, leftNext;
    logic [2:0] stepReg, stepNext; // 0 addrW,1 index,2 data,3 addrR,4 rdata
    logic sclLowReg, sclLowNext, sdaLowReg, sdaLowNext, nackReg, nackNext, strobe;
    logic readReg, readNext, selReg, selNext;
    logic [7:0] idxReg, idxNext;
    logic sda1Reg, sda2Reg;
    logic tick;

    assign tick = timeReg == 8'(LINK_HALF_CYC - 1);

    always_comb begin
        stateNext = stateReg;
        phaseNext = phaseReg;
        timeNext = tick ? 8'h00 : timeReg + 8'h01;
        shiftNext = shiftReg;
        rdNext = rdReg;
        bitNext = bitReg;
        leftNext = leftReg;
        stepNext = stepReg;
        sclLowNext = sclLowReg;
        sdaLowNext = sdaLowReg;
        nackNext = nackReg;
        readNext = readReg;
        selNext = selReg;
        idxNext = idxReg;
        strobe = 1'b0;
        case (stateReg)
            M_IDLE: begin
                timeNext = 8'h00;
                phaseNext = 2'h0;
                if (cmdValid) begin
                    stateNext = M_START;
                    readNext = cmdRead;
                    selNext = addrSel;
                    idxNext = cmdIndex;
                    leftNext = cmdLen;
                    nackNext = 1'b0;
                    stepNext = 3'h0;
                    shiftNext = {ADDR_UPPER, addrSel, DIR_WRITE};
                end
            end
            M_START, M_RSTART: if (tick) begin
                phaseNext = phaseReg + 2'h1;
                case (phaseReg)
                    2'h0: begin sdaLowNext = 1'b0; sclLowNext = 1'b0; end
                    2'h1: sdaLowNext = 1'b1; // Falls while clock high
                    default: begin
                        sclLowNext = 1'b1;
                        sdaLowNext = !shiftReg[7];
                        bitNext = 4'h0;
                        phaseNext = 2'h0;
                        stateNext = M_BYTE;
                    end
                endcase
            end
            M_BYTE, M_ACK: if (tick) begin
                sclLowNext = !sclLowReg;
                if (!sclLowReg) begin
                    // Sample at the end of the high phase: the far end only moves data
                    // a few clocks after it sees the fall, so a sample at the rise is stale
                    if (stateReg == M_BYTE && stepReg == 3'h4) begin
                        rdNext = {rdReg[6:0], sda2Reg};
                    end
                    if (stateReg == M_ACK && stepReg != 3'h4 && sda2Reg == NACK_LEVEL) begin
                        nackNext = 1'b1;
                    end
                    if (stateReg == M_BYTE && bitReg != BIT_LAST) begin
                        bitNext = bitReg + 4'h1;
                        shiftNext = {shiftReg[6:0], 1'b1};
                        sdaLowNext = !shiftReg[6];
                    end else if (stateReg == M_BYTE) begin
                        stateNext = M_ACK;
                        // Read data: ack all but last byte
                        sdaLowNext = stepReg == 3'h4 && leftReg != 4'h1;
                    end else begin
                        sdaLowNext = 1'b0;
                        stateNext = M_BYTE;
                        bitNext = 4'h0;
                        if (stepReg == 3'h4) begin
                            strobe = 1'b1;
                            leftNext = leftReg - 4'h1;
                            if (leftReg == 4'h1) stateNext = M_STOP;
                            shiftNext = 8'hff;
                        end else if (nackNext) begin
                            stateNext = M_STOP;
                        end else if (stepReg == 3'h0) begin
                            stepNext = 3'h1;
                            shiftNext = idxReg;
                            sdaLowNext = !idxReg[7];
                        end else if (stepReg == 3'h1 && readReg) begin
                            stepNext = 3'h3;
                            shiftNext = {ADDR_UPPER, selReg, DIR_READ};
                            phaseNext = 2'h0;
                            stateNext = M_RSTART;
                        end else if (stepReg == 3'h3) begin
                            stepNext = 3'h4;
                            shiftNext = 8'hff;
                        end else begin
                            if (stepReg == 3'h2) begin
                                strobe = 1'b1;
                                leftNext = leftReg - 4'h1;
                            end
                            stepNext = 3'h2;
                            if (stepReg == 3'h2 && leftReg == 4'h1) begin
                                stateNext = M_STOP;
                            end else begin
                                shiftNext = wrByte;
                                sdaLowNext = !wrByte[7];
                            end
                        end
                    end
                end else if (stateReg == M_BYTE) begin
                    shiftNext = stepReg == 3'h4 ? {shiftReg[6:0], 1'b1} : shiftReg;
                end
            end
            M_STOP: if (tick) begin
                phaseNext = phaseReg + 2'h1;
                case (phaseReg)
                    2'h0: sdaLowNext = 1'b1;
                    2'h1: sclLowNext = 1'b0;
                    default: begin sdaLowNext = 1'b0; stateNext = M_DONE; end
                endcase
            end
            default: stateNext = M_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            stateReg <= M_IDLE;
            phaseReg <= 2'h0;
            timeReg <= 8'h00;
            shiftReg <= WORD_RESET;
            rdReg <= WORD_RESET;
            bitReg <= 4'h0;
            leftReg <= 4'h0;
            stepReg <= 3'h0;
            sclLowReg <= 1'b0;
            sdaLowReg <= 1'b0;
            nackReg <= 1'b0;
            readReg <= 1'b0;
            selReg <= 1'b0;
            idxReg <= WORD_RESET;
            sda1Reg <= 1'b1;
            sda2Reg <= 1'b1;
            byteStrobe <= 1'b0;
        end else begin
            stateReg <= stateNext;
            phaseReg <= phaseNext;
            timeReg <= timeNext;
            shiftReg <= shiftNext;
            rdReg <= rdNext;
            bitReg <= bitNext;
            leftReg <= leftNext;
            stepReg <= stepNext;
            sclLowReg <= sclLowNext;
            sdaLowReg <= sdaLowNext;
            nackReg <= nackNext;
            readReg <= readNext;
            selReg <= selNext;
            idxReg <= idxNext;
            sda1Reg <= bus.sda;
            sda2Reg <= sda1Reg;
            byteStrobe <= strobe;
        end
    end

    assign cmdReady = stateReg == M_IDLE;
    assign rdByte = rdReg;
    assign nackSeen = nackReg;
    assign bus.sclOut = 1'b0;
    assign bus.sclOe = sclLowReg;
    assign bus.sdaMstOut = 1'b0;
    assign bus.sdaMstOe = sdaLowReg;
endmodule
`default_nettype wire

// file: testbench/synth_i2c_assertions.sv
// Concurrent checks on the two-wire link between master and register port
`timescale 1ns/1ns
`default_nettype none
module synth_i2c_assertions
    import synth_i2c_pkg::*;
(
    input wire logic clock, // System clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic sclOe, // Master pulls clock low
    input wire logic sdaMstOe, // Master pulls data low
    input wire logic sdaDevOe, // Device pulls data low
    input wire logic scl, // Resolved clock level
    input wire logic sda, // Resolved data level
    input wire logic busAddressSelectPin // Address select strap
);
    // ------------------------------------------------------------
    // Bit and byte tracking
    // ------------------------------------------------------------
    logic sclQ_reg, sclQ_next, sdaQ_reg, sdaQ_next;
    logic first_reg, first_next, sel_reg, sel_next, rd_reg, rd_next;
    logic [3:0] bitCnt_reg, bitCnt_next;
    logic [7:0] shift_reg, shift_next;
    wire sclRise = scl && !sclQ_reg;
    wire startSeen = scl && sclQ_reg && sdaQ_reg && !sda;
    wire ackSlot = sclRise && (bitCnt_reg == BIT_ACK);
    wire addrHit = (shift_reg[7:1] == {ADDR_UPPER, busAddressSelectPin});

    // Restart on START, shift on rising clock, close the byte at its ninth slot
    always_comb begin
        sclQ_next = scl;
        sdaQ_next = sda;
        bitCnt_next = bitCnt_reg;
        shift_next = shift_reg;
        first_next = first_reg;
        sel_next = sel_reg;
        rd_next = rd_reg;
        if (startSeen) begin
            bitCnt_next = 4'h0;
            first_next = 1'b1;
        end else if (ackSlot) begin
            bitCnt_next = 4'h0;
            first_next = 1'b0;
            if (first_reg) begin
                sel_next = addrHit;
                rd_next = shift_reg[0];
            end
        end else if (sclRise) begin
            shift_next = {shift_reg[6:0], sda};
            bitCnt_next = bitCnt_reg + 4'h1;
        end
    end

    // Idle bus levels after reset, so no false START is seen
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sclQ_reg <= 1'b1;
            sdaQ_reg <= 1'b1;
            bitCnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            first_reg <= 1'b0;
            sel_reg <= 1'b0;
            rd_reg <= 1'b0;
        end else begin
            sclQ_reg <= sclQ_next;
            sdaQ_reg <= sdaQ_next;
            bitCnt_reg <= bitCnt_next;
            shift_reg <= shift_next;
            first_reg <= first_next;
            sel_reg <= sel_next;
            rd_reg <= rd_next;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_addr_hit; ackSlot && first_reg && addrHit; endsequence
    sequence s_addr_miss; ackSlot && first_reg && !addrHit; endsequence
    sequence s_wr_slot; ackSlot && !first_reg && sel_reg && !rd_reg; endsequence
    sequence s_rd_slot; ackSlot && !first_reg && sel_reg && rd_reg; endsequence

    addr_ack_a: assert property (s_addr_hit |-> !sda && sdaDevOe)
        else $error("own address not acknowledged");
    foreign_nack_a: assert property (s_addr_miss |-> sda)
        else $error("foreign address acknowledged");
    idle_quiet_a: assert property (!first_reg && !sel_reg |-> !sdaDevOe)
        else $error("unaddressed device drives data");
    addr_quiet_a: assert property (first_reg && bitCnt_reg != BIT_ACK |-> !sdaDevOe)
        else $error("device drives data during address bits");
    wr_ack_a: assert property (s_wr_slot |-> !sda)
        else $error("written byte not acknowledged");
    rd_release_a: assert property (s_rd_slot |-> !sdaDevOe)
        else $error("device holds data in master ack slot");
    dev_stable_a: assert property (scl && sclQ_reg |-> $stable(sdaDevOe))
        else $error("device data changes while clock high");
    scl_high_a: assert property ($fell(sclOe) |-> (!sclOe) [*4])
        else $error("clock high phase too short");
    start_owner_a: assert property ($fell(sda) && scl |-> sdaMstOe)
        else $error("START not made by master");
endmodule
`default_nettype wire

// file: testbench/clock_synth_i2c_reg_port_tb_top.sv
// Self-checking bench joining the master and register port ends
`timescale 1ns/1ns
`default_nettype none
module clock_synth_i2c_reg_port_tb_top
    import synth_i2c_pkg::*;
();
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic clock, rst_b, cmdValid, cmdRead, addrSel, addrStrap, cmdReady, byteStrobe;
    logic nackSeen, internalFilterSel, fsel;
    logic [7:0] cmdIndex, wrByte, rdByte, regIndex, curIdx, rIdx, rData;
    logic [3:0] cmdLen, rLen;
    logic [7:0] mem [32];
    int fail_count, n_compared, r;
    synth_i2c_if bus ();
    // Open-drain wires with pull-ups
    assign bus.scl = !bus.sclOe;
    assign bus.sda = !(bus.sdaMstOe | bus.sdaDevOe);
    synth_i2c_master u_synth_i2c_master (.clock(clock), .rst_b(rst_b), .bus(bus),
        .cmdValid(cmdValid), .cmdRead(cmdRead), .addrSel(addrSel), .cmdIndex(cmdIndex),
        .cmdLen(cmdLen), .wrByte(wrByte), .cmdReady(cmdReady), .byteStrobe(byteStrobe),
        .rdByte(rdByte), .nackSeen(nackSeen));
    synth_i2c_device u_synth_i2c_device (.clock(clock), .rst_b(rst_b), .bus(bus),
        .busAddressSelectPin(addrStrap), .internalFilterSel(internalFilterSel),
        .regIndex(regIndex));
    synth_i2c_assertions u_synth_i2c_assertions (.clock(clock), .rst_b(rst_b),
        .sclOe(bus.sclOe), .sdaMstOe(bus.sdaMstOe), .sdaDevOe(bus.sdaDevOe),
        .scl(bus.scl), .sda(bus.sda), .busAddressSelectPin(addrStrap));

    // ------------------------------------------------------------
    // Compare and closing tasks
    // ------------------------------------------------------------
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // One transaction; the bench model tracks index, registers and filter select
    task automatic xfer(input logic rd, input logic sel, input logic [7:0] idx,
        input logic [3:0] len, input logic [7:0] d0);
        logic [7:0] d;
        logic hit;
        int k;
        int w;
        d = d0;
        hit = (sel == addrStrap);
        cmdRead = rd;
        addrSel = sel;
        cmdIndex = idx;
        cmdLen = len;
        wrByte = d;
        cmdValid = 1'b1;
        @(negedge clock);
        cmdValid = 1'b0;
        if (hit) curIdx = idx;
        for (k = 0; k < len && hit; k++) begin
            w = 0;
            while (byteStrobe !== 1'b1 && w < 2000) begin
                @(negedge clock);
                w++;
            end
            chk_bit(byteStrobe, 1'b1);
            if (rd) begin
                chk_byte(rdByte, mem[curIdx[4:0]]);
            end else begin
                mem[curIdx[4:0]] = d;
                if (curIdx == LOOP_FILTER_IDX) fsel = d[LOOP_FILTER_BIT];
            end
            curIdx[3:0] = curIdx[3:0] + 4'h1;
            // The master took the next byte from wrByte as it raised the strobe
            d = wrByte;
            wrByte = 8'($urandom);
            @(negedge clock);
        end
        w = 0;
        while (cmdReady !== 1'b1 && w < 4000) begin
            @(negedge clock);
            w++;
        end
        chk_bit(cmdReady, 1'b1);
        chk_bit(nackSeen, !hit);
        chk_byte(regIndex, curIdx);
        chk_bit(internalFilterSel, fsel);
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Longest expected run is well under this span
    initial begin
        #(90000 * 40);
        fail_count++;
        end_of_test();
    end
    initial begin
        fail_count = 0;
        n_compared = 0;
        rst_b = 1'b0;
        {cmdValid, cmdRead, addrSel, addrStrap, fsel} = 5'h00;
        cmdIndex = 8'h00;
        cmdLen = 4'h1;
        wrByte = 8'h00;
        curIdx = 8'h00;
        void'($urandom(32'h910e));
        repeat (16) @(negedge clock);
        rst_b = 1'b1;
        repeat (4) @(negedge clock);
        chk_byte(regIndex, 8'h00);
        chk_bit(internalFilterSel, 1'b0);
        // Filter select on, read back, then off again
        xfer(1'b0, 1'b0, 8'h04, 4'h1, 8'h80);
        xfer(1'b1, 1'b0, 8'h04, 4'h1, 8'h00);
        xfer(1'b0, 1'b0, 8'h04, 4'h1, 8'h7f);
        // Lower nibble wraps with no carry into the upper one
        xfer(1'b0, 1'b0, 8'h0e, 4'h4, 8'ha5);
        xfer(1'b1, 1'b0, 8'h0e, 4'h4, 8'h00);
        xfer(1'b0, 1'b0, 8'h1f, 4'h2, 8'h3c);
        xfer(1'b1, 1'b0, 8'h1f, 4'h2, 8'h00);
        // Registers 00-08 and 10-12 in two transactions each way
        xfer(1'b0, 1'b0, 8'h00, 4'h9, 8'h5a);
        xfer(1'b0, 1'b0, 8'h10, 4'h3, 8'hc3);
        xfer(1'b1, 1'b0, 8'h00, 4'h9, 8'h00);
        xfer(1'b1, 1'b0, 8'h10, 4'h3, 8'h00);
        // Other strap level, then foreign addresses in both directions
        addrStrap = 1'b1;
        repeat (4) @(negedge clock);
        xfer(1'b0, 1'b1, 8'h02, 4'h2, 8'h11);
        xfer(1'b1, 1'b1, 8'h02, 4'h2, 8'h00);
        xfer(1'b0, 1'b0, 8'h03, 4'h1, 8'h22);
        xfer(1'b1, 1'b0, 8'h02, 4'h1, 8'h00);
        // Random bursts, strap flipped half way
        for (r = 0; r < 8; r++) begin
            if (r == 4) addrStrap = 1'b0;
            if (r == 4) repeat (4) @(negedge clock);
            rIdx = 8'($urandom % 32);
            rLen = 4'(1 + $urandom % 15);
            rData = 8'($urandom);
            xfer(1'b0, addrStrap, rIdx, rLen, rData);
            xfer(1'b1, addrStrap, rIdx, rLen, 8'h00);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
